//--- rtl/ext_bus_pkg.sv
// Constants and types for the external bus wait-state and bank-switch block
package ext_bus_pkg;
   localparam logic [6:0]  OFS_WAIT_RANGES   = 7'h28;
   localparam logic [6:0]  OFS_BANK_SWITCH   = 7'h29;
   localparam logic [6:0]  OFS_WAIT_CONTROL  = 7'h2b;
   localparam logic [15:0] RST_WAIT_RANGES   = 16'h7fff;
   localparam logic [15:0] RST_BANK_SWITCH   = 16'h7000;
   localparam logic [15:0] RST_WAIT_CONTROL  = 16'h0000;
   localparam logic [15:0] MASK_BANK_SWITCH  = 16'hf006;
   localparam logic [15:0] MASK_WAIT_CONTROL = 16'h0001;
   localparam logic [14:0] ALL_ZERO_WAITS    = 15'h0000;
   localparam int          PROG_SEL_BIT      = 15;
   localparam int          IO_LSB            = 12;
   localparam int          DATA_HI_LSB       = 9;
   localparam int          DATA_LO_LSB       = 6;
   localparam int          PROG_HI_LSB       = 3;
   localparam int          PROG_LO_LSB       = 0;
   localparam int          MULT_BIT          = 0;
   localparam int          CONSECUTIVE_BIT   = 15;
   localparam int          BANK_BIT          = 15;
   localparam int          PROG_HALF_BIT     = 22;
   localparam int          PAGE_LSB          = 16;
   localparam logic [3:0]  MAX_WAITS         = 4'he;
   localparam logic [3:0]  ZERO_COUNT        = 4'h0;
   localparam logic [3:0]  ONE_COUNT         = 4'h1;
   localparam logic [1:0]  SP_PROG           = 2'h0;
   localparam logic [1:0]  SP_DATA           = 2'h1;
   localparam logic [1:0]  SP_IO             = 2'h2;
   typedef enum logic [1:0] {st_idle, st_lead, st_wait, st_trail} acc_state_e;
endpackage

//--- rtl/ext_bus_wait_state_bank_switch.sv
// External bus cycle stretcher: wait-state generator and bank-switch gaps
`timescale 1ns/1ns
// Summary of operation
// - Each external cycle can be stretched by programmed waits, fourteen at most.
// - Slow devices hold ready low; the cycle extends until ready returns.
// - All ranges at zero waits stops the wait counter clocking.
// - Reset gives seven waits everywhere: all fields ones, multiplier one.
// - Bit 15 of wait ranges selects which program ranges the fields cover.
// - Bits 14-12 set base waits for all I/O accesses.
// - Bits 11-9 set base waits for data addresses 8000-FFFFh.
// - Bits 8-6 set base waits for data addresses 0000-7FFFh.
// - Bits 5-3 set upper program waits; select picks per-page or 400000h up.
// - Bits 2-0 set lower program waits; select picks per-page or below 400000h.
// - Control bit 0 doubles every base count when set.
// - Control bits 15-1 are reserved and unchanged by writes.
// - Crossing a 32K-word bank on a program or data read inserts one cycle.
// - Non-consecutive mode keeps last bank bit; a mismatching read withholds strobe once.
// - Program-data, data-program and cross-page program reads add one cycle.
// - Consecutive mode makes every memory read a lead, read and trailing cycle.
module ext_bus_wait_state_bank_switch
   import ext_bus_pkg::*;
#(
   parameter int ADDR_W = 23
)(
   input  wire logic              clk_sys,
   input  wire logic              srst,
   input  wire logic [6:0]        mmr_addr,
   input  wire logic              mmr_wr,
   input  wire logic              mmr_rd,
   input  wire logic [15:0]       mmr_wdata,
   output logic      [15:0]       mmr_rdata,
   input  wire logic              acc_req,
   input  wire logic [1:0]        acc_space,
   input  wire logic              acc_read,
   input  wire logic [ADDR_W-1:0] acc_addr,
   input  wire logic              ext_ready,
   output logic                   acc_busy,
   output logic                   acc_done,
   output logic      [ADDR_W-1:0] bus_addr,
   output logic                   memory_strobe_n,
   output logic                   io_strobe_n,
   output logic                   ws_clk_en
);

////////////////////////////////////////////////////////////////////////////////
// Registers
logic [15:0] ranges_r, ranges_nxt;
logic [15:0] bank_r, bank_nxt;
logic [15:0] ctrl_r, ctrl_nxt;
logic [15:0] rdata_r, rdata_nxt;
logic        ws_en_r, ws_en_nxt;

always_comb begin
   ranges_nxt = ranges_r;
   bank_nxt   = bank_r;
   ctrl_nxt   = ctrl_r;
   rdata_nxt  = rdata_r;
   if (mmr_wr) begin
      unique case (mmr_addr)
         OFS_WAIT_RANGES:  ranges_nxt = mmr_wdata;
         OFS_BANK_SWITCH:  bank_nxt   = mmr_wdata & MASK_BANK_SWITCH;
         OFS_WAIT_CONTROL: ctrl_nxt   = mmr_wdata & MASK_WAIT_CONTROL;
         default: ;
      endcase
   end
   if (mmr_rd) begin
      unique case (mmr_addr)
         OFS_WAIT_RANGES:  rdata_nxt = ranges_r;
         OFS_BANK_SWITCH:  rdata_nxt = bank_r;
         OFS_WAIT_CONTROL: rdata_nxt = ctrl_r;
         default:          rdata_nxt = 16'h0000;
      endcase
   end
   // Registered, so the gate lags a write by one cycle; harmless while idle
   // The I/O field reaches bit 14, so all fifteen field bits decide the gate
   ws_en_nxt = (ranges_r[14:0] != ALL_ZERO_WAITS);
end

always_ff @(posedge clk_sys) begin
   if (srst) begin
      ranges_r <= RST_WAIT_RANGES;
      bank_r   <= RST_BANK_SWITCH;
      ctrl_r   <= RST_WAIT_CONTROL;
      rdata_r  <= 16'h0000;
      ws_en_r  <= 1'b1;
   end else begin
      ranges_r <= ranges_nxt;
      bank_r   <= bank_nxt;
      ctrl_r   <= ctrl_nxt;
      rdata_r  <= rdata_nxt;
      ws_en_r  <= ws_en_nxt;
   end
end

assign mmr_rdata = rdata_r;
assign ws_clk_en = ws_en_r;

////////////////////////////////////////////////////////////////////////////////
// Wait selection and bank-switch decision
logic [2:0] base_sel;
logic [3:0] ws_sel;
logic       is_mem;
logic       prog_hi;
logic       take;
logic       gap;

always_comb begin
   prog_hi = ranges_r[PROG_SEL_BIT] ? acc_addr[PROG_HALF_BIT] : acc_addr[BANK_BIT];
   unique case (acc_space)
      SP_IO:   base_sel = ranges_r[IO_LSB +: 3];
      SP_DATA: base_sel = acc_addr[BANK_BIT] ? ranges_r[DATA_HI_LSB +: 3]
                                             : ranges_r[DATA_LO_LSB +: 3];
      default: base_sel = prog_hi ? ranges_r[PROG_HI_LSB +: 3]
                                  : ranges_r[PROG_LO_LSB +: 3];
   endcase
   // Doubling by shift keeps the top at fourteen
   ws_sel = ctrl_r[MULT_BIT] ? {base_sel, 1'b0} : {1'b0, base_sel};
end

////////////////////////////////////////////////////////////////////////////////
// Access sequencer
acc_state_e          st_r, st_nxt;
logic [3:0]          cnt_r, cnt_nxt;
logic [ADDR_W-1:0]   addr_r, addr_nxt;
logic [1:0]          space_r, space_nxt;
logic                read_r, read_nxt;
logic                done_r, done_nxt;
logic                mstb_n_r, mstb_n_nxt;
logic                istb_n_r, istb_n_nxt;
logic                last_vld_r, last_vld_nxt;
logic                last_msb_r, last_msb_nxt;
logic                last_read_r, last_read_nxt;
logic [1:0]          last_sp_r, last_sp_nxt;
logic [6:0]          last_pg_r, last_pg_nxt;
logic                consecutive_bank_mode;

assign consecutive_bank_mode = bank_r[CONSECUTIVE_BIT];
assign is_mem = (acc_space != SP_IO);
assign take   = acc_req && (st_r == st_idle);

always_comb begin
   gap = 1'b0;
   if (acc_read && is_mem) begin
      if (consecutive_bank_mode)
         gap = 1'b1;
      else if (last_vld_r) begin
         if (last_msb_r != acc_addr[BANK_BIT])
            gap = 1'b1;
         if (last_read_r && last_sp_r != acc_space)
            gap = 1'b1;
         if (last_read_r && acc_space == SP_PROG && last_sp_r == SP_PROG &&
             last_pg_r != acc_addr[PAGE_LSB +: 7])
            gap = 1'b1;
      end
   end
end

always_comb begin
   st_nxt        = st_r;
   cnt_nxt       = cnt_r;
   addr_nxt      = addr_r;
   space_nxt     = space_r;
   read_nxt      = read_r;
   done_nxt      = 1'b0;
   last_vld_nxt  = last_vld_r;
   last_msb_nxt  = last_msb_r;
   last_read_nxt = last_read_r;
   last_sp_nxt   = last_sp_r;
   last_pg_nxt   = last_pg_r;
   unique case (st_r)
      st_idle: begin
         if (take) begin
            addr_nxt  = acc_addr;
            space_nxt = acc_space;
            read_nxt  = acc_read;
            // Counter loads only while its clock is live
            cnt_nxt   = ws_en_r ? ws_sel : ZERO_COUNT;
            st_nxt    = gap ? st_lead : st_wait;
            if (is_mem) begin
               last_vld_nxt  = 1'b1;
               last_msb_nxt  = acc_addr[BANK_BIT];
               last_read_nxt = acc_read;
               last_sp_nxt   = acc_space;
               last_pg_nxt   = acc_addr[PAGE_LSB +: 7];
            end
         end
      end
      st_lead: st_nxt = st_wait;
      st_wait: begin
         if (cnt_r != ZERO_COUNT && ws_en_r)
            cnt_nxt = cnt_r - ONE_COUNT;
         else if (ext_ready) begin
            done_nxt = 1'b1;
            st_nxt   = (consecutive_bank_mode && read_r && space_r != SP_IO) ? st_trail
                                                                             : st_idle;
         end
      end
      st_trail: st_nxt = st_idle;
   endcase
   mstb_n_nxt = !(st_nxt == st_wait && space_nxt != SP_IO);
   istb_n_nxt = !(st_nxt == st_wait && space_nxt == SP_IO);
end

always_ff @(posedge clk_sys) begin
   if (srst) begin
      st_r        <= st_idle;
      cnt_r       <= ZERO_COUNT;
      addr_r      <= '0;
      space_r     <= SP_PROG;
      read_r      <= 1'b0;
      done_r      <= 1'b0;
      mstb_n_r    <= 1'b1;
      istb_n_r    <= 1'b1;
      last_vld_r  <= 1'b0;
      last_msb_r  <= 1'b0;
      last_read_r <= 1'b0;
      last_sp_r   <= SP_PROG;
      last_pg_r   <= 7'h00;
   end else begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      addr_r      <= addr_nxt;
      space_r     <= space_nxt;
      read_r      <= read_nxt;
      done_r      <= done_nxt;
      mstb_n_r    <= mstb_n_nxt;
      istb_n_r    <= istb_n_nxt;
      last_vld_r  <= last_vld_nxt;
      last_msb_r  <= last_msb_nxt;
      last_read_r <= last_read_nxt;
      last_sp_r   <= last_sp_nxt;
      last_pg_r   <= last_pg_nxt;
   end
end

logic busy_r;
logic busy_nxt;
assign busy_nxt = (st_nxt != st_idle);
always_ff @(posedge clk_sys) begin
   if (srst)
      busy_r <= 1'b0;
   else
      busy_r <= busy_nxt;
end

assign acc_busy        = busy_r;
assign acc_done        = done_r;
assign bus_addr        = addr_r;
assign memory_strobe_n = mstb_n_r;
assign io_strobe_n     = istb_n_r;

////////////////////////////////////////////////////////////////////////////////
// Checks
property p_max_wait;
   @(posedge clk_sys) disable iff (srst) cnt_r <= MAX_WAITS;
endproperty
a_max_wait: assert property (p_max_wait) else $error("wait count above fourteen");

property p_ready_hold;
   @(posedge clk_sys) disable iff (srst)
      (st_r == st_wait && cnt_r == ZERO_COUNT && !ext_ready) |=> (st_r == st_wait && !acc_done);
endproperty
a_ready_hold: assert property (p_ready_hold) else $error("cycle ended without ready");

property p_gate;
   @(posedge clk_sys) disable iff (srst)
      (ranges_r[14:0] == ALL_ZERO_WAITS) |=> !ws_clk_en;
endproperty
a_gate: assert property (p_gate) else $error("wait clock not gated");

property p_reset_vals;
   @(posedge clk_sys) srst |=> (ranges_r == RST_WAIT_RANGES && ctrl_r == RST_WAIT_CONTROL);
endproperty
a_reset_vals: assert property (p_reset_vals) else $error("bad reset wait setup");

property p_load;
   @(posedge clk_sys) disable iff (srst)
      (take && ws_en_r) |=> cnt_r == ($past(ctrl_r[MULT_BIT]) ? {$past(base_sel), 1'b0}
                                                              : {1'b0, $past(base_sel)});
endproperty
a_load: assert property (p_load) else $error("wrong wait count loaded");

property p_reserved;
   @(posedge clk_sys) disable iff (srst) ctrl_r[15:1] == 15'h0000;
endproperty
a_reserved: assert property (p_reserved) else $error("reserved control bits changed");

property p_gap;
   @(posedge clk_sys) disable iff (srst)
      (take && gap) |=> (st_r == st_lead && memory_strobe_n) ##1 !memory_strobe_n;
endproperty
a_gap: assert property (p_gap) else $error("bank gap not inserted");

property p_consecutive_bank_mode;
   @(posedge clk_sys) disable iff (srst)
      (take && consecutive_bank_mode && acc_read && is_mem) |=> st_r == st_lead;
endproperty
a_consecutive_bank_mode: assert property (p_consecutive_bank_mode) else $error("no lead cycle in consecutive mode");

property p_trail;
   @(posedge clk_sys) disable iff (srst)
      (acc_done && consecutive_bank_mode && read_r && space_r != SP_IO) |-> st_r == st_trail;
endproperty
a_trail: assert property (p_trail) else $error("no trailing cycle");

c_gap:   cover property (@(posedge clk_sys) disable iff (srst) st_r == st_lead);
c_stall: cover property (@(posedge clk_sys) disable iff (srst)
                         st_r == st_wait && cnt_r == ZERO_COUNT && !ext_ready);
c_max:   cover property (@(posedge clk_sys) disable iff (srst) take && ws_sel == MAX_WAITS);
c_trail: cover property (@(posedge clk_sys) disable iff (srst) st_r == st_trail);

endmodule

//--- verification/ext_device.sv
// Model of a slow external memory or I/O device driving the ready line
`timescale 1ns/1ns
module ext_device (
   input  wire logic       clk_sys,
   input  wire logic       memory_strobe_n,
   input  wire logic       io_strobe_n,
   input  wire logic [3:0] slow,
   output logic            ext_ready
);
   logic [3:0] held_r = 4'h0;
   logic       junk_r = 1'b0;
   logic       sel;
   assign sel = !(memory_strobe_n && io_strobe_n);
   always_ff @(posedge clk_sys) begin
      held_r <= sel ? held_r + 4'h1 : 4'h0;
      junk_r <= !junk_r;
   end
   // Not selected: line wanders, so a design sampling it then is caught
   assign ext_ready = sel ? (held_r >= slow) : junk_r;
endmodule

//--- verification/testbench.sv
// Self-checking bench for the wait-state and bank-switch block
`timescale 1ns/1ns
module testbench;
   import ext_bus_pkg::*;
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
   logic        clk_sys = 1'b0, srst = 1'b1, mmr_wr = 1'b0, mmr_rd = 1'b0;
   logic [6:0]  mmr_addr = 7'h00;
   logic [15:0] mmr_wdata = 16'h0000, mmr_rdata, wsr, swc, bsc;
   logic        acc_req = 1'b0, acc_read = 1'b0, ext_ready, acc_busy, acc_done;
   logic [1:0]  acc_space = 2'h0, ps;
   logic [22:0] acc_addr = 23'h000000, bus_addr;
   logic        memory_strobe_n, io_strobe_n, ws_clk_en, pv, pb, pr;
   logic [6:0]  pp;
   logic [3:0]  slow = 4'h0;
   int          num_errors = 0, n_compared = 0, c, j;
   integer      seed = 32'h4e15;
   ext_bus_wait_state_bank_switch dut (.clk_sys(clk_sys), .srst(srst), .mmr_addr(mmr_addr),
      .mmr_wr(mmr_wr), .mmr_rd(mmr_rd), .mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata),
      .acc_req(acc_req), .acc_space(acc_space), .acc_read(acc_read), .acc_addr(acc_addr),
      .ext_ready(ext_ready), .acc_busy(acc_busy), .acc_done(acc_done), .bus_addr(bus_addr),
      .memory_strobe_n(memory_strobe_n), .io_strobe_n(io_strobe_n), .ws_clk_en(ws_clk_en));
   ext_device far (.clk_sys(clk_sys), .memory_strobe_n(memory_strobe_n),
      .io_strobe_n(io_strobe_n), .slow(slow), .ext_ready(ext_ready));
   always #5 clk_sys = !clk_sys;
   task automatic results();
      if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Extra idle edge after each strobe so back-to-back calls never retoggle in one step
   task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
      mmr_addr = a;
      mmr_wdata = d;
      mmr_wr = 1'b1;
      @(posedge clk_sys);
      #1 mmr_wr = 1'b0;
      if (a == OFS_WAIT_RANGES) wsr = d;
      if (a == OFS_BANK_SWITCH) bsc = (d & MASK_BANK_SWITCH) | (bsc & ~MASK_BANK_SWITCH);
      if (a == OFS_WAIT_CONTROL) swc = {swc[15:1], d[0]};
      @(posedge clk_sys);
      #1;
   endtask
   task automatic reg_rd(input logic [6:0] a, input logic [15:0] ex);
      mmr_addr = a;
      mmr_rd = 1'b1;
      @(posedge clk_sys);
      #1 mmr_rd = 1'b0;
      `CHK("mmr_rdata", ex, mmr_rdata)
      @(posedge clk_sys);
      #1;
   endtask
   task automatic access(input logic [1:0] sp, input logic rd, input logic [22:0] a);
      int w, gap, lead, low, wrong, trail, k;
      logic done, sn, on;
      w = (sp == SP_IO) ? wsr[14:12] : (sp == SP_DATA) ? (a[15] ? wsr[11:9] : wsr[8:6])
          : ((wsr[15] ? a[22] : a[15]) ? wsr[5:3] : wsr[2:0]);
      w = w * (swc[0] + 1);
      // Only reads pay a gap; space and page changes count after a previous read
      gap = (sp != SP_IO) && rd && (bsc[15] || (pv && (pb != a[15]
            || (pr && (ps != sp || (sp == SP_PROG && pp != a[22:16]))))));
      if (sp != SP_IO) begin
         pv = 1'b1;
         pr = rd;
         pb = a[15];
         ps = sp;
         pp = a[22:16];
      end
      acc_space = sp; acc_read = rd; acc_addr = a; acc_req = 1'b1;
      @(posedge clk_sys);
      #1 acc_req = 1'b0;
      lead = 0; low = 0; wrong = 0; trail = 0; done = 1'b0;
      for (k = 0; k < 60; k++) begin
         sn = (sp == SP_IO) ? io_strobe_n : memory_strobe_n;
         on = (sp == SP_IO) ? memory_strobe_n : io_strobe_n;
         done = done | (acc_done === 1'b1);
         if (on !== 1'b1) wrong++;
         if (done) trail += (acc_busy === 1'b1);
         else if (sn === 1'b0) low++;
         else lead++;
         if (done && acc_busy !== 1'b1) break;
         @(posedge clk_sys);
         #1;
      end
      if (k == 60) begin
         num_errors++;
         results();
      end
      `CHK("lead cycles", gap, lead)
      `CHK("strobe low cycles", ((w > slow) ? w : slow) + 1, low)
      `CHK("trail cycles", (bsc[15] && rd && sp != SP_IO), trail)
      `CHK("other strobe", 0, wrong)
      `CHK("bus_addr", a, bus_addr)
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      #1 srst = 1'b0;
      wsr = RST_WAIT_RANGES; swc = RST_WAIT_CONTROL; bsc = RST_BANK_SWITCH; pv = 1'b0;
      reg_rd(OFS_WAIT_RANGES, 16'h7fff);
      reg_rd(OFS_WAIT_CONTROL, 16'h0000);
      reg_rd(OFS_BANK_SWITCH, RST_BANK_SWITCH);
      access(SP_IO, 1'b0, 23'h001234);
      reg_wr(7'h2a, 16'hffff);
      reg_rd(7'h2a, 16'h0000);
      for (c = 0; c < 16; c++) begin
         reg_wr(OFS_WAIT_RANGES, (c == 1) ? 16'h0000 : 16'($random(seed)));
         reg_wr(OFS_WAIT_CONTROL, (c == 1) ? 16'hffff : 16'($random(seed)));
         reg_wr(OFS_BANK_SWITCH, 16'($random(seed)));
         slow = 4'(c % 4) * 4'h5;
         `CHK("ws_clk_en", (wsr[14:0] != 15'h0000), ws_clk_en)
         reg_rd(OFS_WAIT_RANGES, wsr);
         reg_rd(OFS_WAIT_CONTROL, swc);
         reg_rd(OFS_BANK_SWITCH, bsc);
         for (j = 0; j < 10; j++) begin
            acc_space = 2'(($random(seed) & 32'h7fffffff) % 3);
            access(acc_space, 1'($random(seed)), 23'($random(seed)) & 23'h41ffff);
         end
      end
      // Mid-run reset: setup and gap history must return to their reset state
      srst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 srst = 1'b0;
      wsr = RST_WAIT_RANGES;
      swc = RST_WAIT_CONTROL;
      bsc = RST_BANK_SWITCH;
      pv = 1'b0;
      `CHK("ws_clk_en", 1'b1, ws_clk_en)
      reg_rd(OFS_WAIT_RANGES, RST_WAIT_RANGES);
      reg_rd(OFS_WAIT_CONTROL, RST_WAIT_CONTROL);
      reg_rd(OFS_BANK_SWITCH, RST_BANK_SWITCH);
      access(SP_DATA, 1'b1, 23'h00f000);
      results();
   end
endmodule
